/* File: hdl/usart_status_pkg.sv */
/*
 * Shared constants and carrier types for the serial status and receive
 * holding block.
 * Assumes a word-wide register port with full 32-bit byte addresses.
 */
package usart_status_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] CMD_ADDR = 32'h4002_4000;
	localparam logic [31:0] MODE_ADDR = 32'h4002_4004;
	localparam logic [31:0] IER_ADDR = 32'h4002_4008;
	localparam logic [31:0] IDR_ADDR = 32'h4002_400C;
	localparam logic [31:0] IMR_ADDR = 32'h4002_4010;
	localparam logic [31:0] CSR_ADDR = 32'h4002_4014;
	localparam logic [31:0] RHR_ADDR = 32'h4002_4018;
	localparam logic [31:0] RTOR_ADDR = 32'h4002_4024;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int B_RX_READY = 0;
	localparam int B_TX_READY = 1;
	localparam int B_BREAK = 2;
	localparam int B_RX_END = 3;
	localparam int B_TX_END = 4;
	localparam int B_OVR = 5;
	localparam int B_FRAME = 6;
	localparam int B_PAR = 7;
	localparam int B_TOUT = 8;
	localparam int B_TX_EMPTY = 9;
	localparam int B_UNDER = 10;
	localparam int B_TX_BUF_EMPTY = 11;
	localparam int B_RX_BUF_FULL = 12;
	localparam int B_FLOWCHG = 19;
	localparam int B_FLOWLVL = 23;
	localparam int CMD_STATUS_RESET_BIT = 8;
	localparam int CMD_TIMEOUT_START_BIT = 11;
	localparam int RHR_SYNC_BIT = 15;
	localparam int MODE_W = 4;
	localparam int RTOR_W = 16;

	// ------------------------------------------------------------
	// Values
	// ------------------------------------------------------------
	localparam logic [31:0] IMR_VALID = 32'h0008_1FFF;
	localparam logic [31:0] IMR_RESET = 32'h0000_0000;
	localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
	localparam logic [MODE_W-1:0] MODE_SPI_MASTER = 4'hE;
	localparam logic [MODE_W-1:0] MODE_SPI_SLAVE = 4'hF;
	localparam logic [RTOR_W-1:0] RTOR_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic charDone;
		logic [8:0] charData;
		logic charSync;
		logic breakSeen;
		logic frameErr;
		logic parityErr;
		logic underrun;
		logic timeoutHit;
	} rxEvents_t;

	typedef struct packed {
		logic holdWrite;
		logic holdLoad;
		logic shiftBusy;
		logic breakPending;
	} txState_t;

	typedef struct packed {
		logic rxReachedZero;
		logic rxCntWrite;
		logic rxBothZero;
		logic txReachedZero;
		logic txCntWrite;
		logic txBothZero;
	} dmaState_t;

endpackage : usart_status_pkg

/* File: hdl/usart_status_rx.sv */
/*
 * Status flags, interrupt mask and receive holding register of a serial
 * transceiver with asynchronous and SPI modes.
 * Assumes receiver, transmitter and DMA counters sit outside and report
 * single-cycle events synchronous to clk_sys.
 */
// Summary of operation
// - Character arrival sets ready; holding read clears
// - Ready reads zero while receiver disabled
// - Transmit ready low: pending char, break outside SPI modes, disabled
// - Break or break end sets sticky flag
// - Receive DMA counter zero sets end flag
// - Transmit DMA counter zero sets end flag
// - Overrun stays set until status reset
// - Low stop bit sets sticky framing flag
// - Parity mismatch sets sticky parity flag
// - Timeout flag; zero value keeps it low
// - Empty only when holding and shifter empty
// - Both DMA counters zero give full/empty
// - Flow input transition sets change flag
// - Status bit mirrors flow input level
// - SPI layout only for modes E, F
// - SPI underrun sticky until status reset
// - Select edge sets event, read clears
// - Select level shows edge direction
// - Holding register shows nine-bit character
// - Bit 15 marks data or command
// - Interrupt only from unmasked status flags
`timescale 1ns/1ps

module usart_status_rx #(
	parameter int ADDR_W = 32,
	parameter int CHAR_W = 9
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// Receiver and transmitter side
	input wire usart_status_pkg::rxEvents_t rxEvents,
	input wire usart_status_pkg::txState_t txState,
	input wire usart_status_pkg::dmaState_t dmaState,
	input wire logic rxEnable,
	input wire logic txEnable,
	// Flow-control pin, also the select line in SPI mode
	input wire logic flowIn,
	// Interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (ADDR_W != 32) begin : g_addr_chk
		$error("ADDR_W must be 32");
	end
	if (CHAR_W != 9) begin : g_char_chk
		$error("CHAR_W must be 9");
	end

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic wrCmd, wrMode, wrIer, wrIdr, wrRtor, rdCsr, rdRhr;
	logic rstStatus, startTimeout, spiMode;
	logic [usart_status_pkg::MODE_W-1:0] mode_reg;
	logic [usart_status_pkg::RTOR_W-1:0] rtor_reg;
	logic [31:0] imr_reg;

	// Strobes qualified by address; unmapped writes do nothing
	assign wrCmd = regWr && (regAddr == usart_status_pkg::CMD_ADDR);
	assign wrMode = regWr && (regAddr == usart_status_pkg::MODE_ADDR);
	assign wrIer = regWr && (regAddr == usart_status_pkg::IER_ADDR);
	assign wrIdr = regWr && (regAddr == usart_status_pkg::IDR_ADDR);
	assign wrRtor = regWr && (regAddr == usart_status_pkg::RTOR_ADDR);
	assign rdCsr = regRd && (regAddr == usart_status_pkg::CSR_ADDR);
	assign rdRhr = regRd && (regAddr == usart_status_pkg::RHR_ADDR);
	assign rstStatus = wrCmd && regWdata[usart_status_pkg::CMD_STATUS_RESET_BIT];
	assign startTimeout = wrCmd && regWdata[usart_status_pkg::CMD_TIMEOUT_START_BIT];
	// Only the two SPI codes switch layout
	assign spiMode = (mode_reg == usart_status_pkg::MODE_SPI_MASTER) ||
		(mode_reg == usart_status_pkg::MODE_SPI_SLAVE);

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Mode and timeout value
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_reg <= usart_status_pkg::MODE_RESET;
			rtor_reg <= usart_status_pkg::RTOR_RESET;
		end else begin
			if (wrMode) begin
				mode_reg <= regWdata[usart_status_pkg::MODE_W-1:0];
			end
			if (wrRtor) begin
				rtor_reg <= regWdata[usart_status_pkg::RTOR_W-1:0];
			end
		end
	end

	// Mask: enable sets, disable clears; reserved positions never stick
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			imr_reg <= usart_status_pkg::IMR_RESET;
		end else if (wrIer) begin
			imr_reg <= imr_reg | (regWdata & usart_status_pkg::IMR_VALID);
		end else if (wrIdr) begin
			imr_reg <= imr_reg & ~regWdata;
		end
	end

	// ------------------------------------------------------------
	// Receive holding
	// ------------------------------------------------------------
	logic rxPending_reg;
	logic [CHAR_W-1:0] rxChar_reg;
	logic rxSync_reg;

	// Characters are caught even while disabled, so ready reappears later
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rxPending_reg <= 1'b0;
		end else if (rxEvents.charDone) begin
			rxPending_reg <= 1'b1;
		end else if (rdRhr) begin
			rxPending_reg <= 1'b0;
		end
	end

	// Character and its sync marker
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rxChar_reg <= '0;
			rxSync_reg <= 1'b0;
		end else if (rxEvents.charDone) begin
			rxChar_reg <= rxEvents.charData;
			rxSync_reg <= rxEvents.charSync;
		end
	end

	// ------------------------------------------------------------
	// Transmit holding state
	// ------------------------------------------------------------
	logic holdFull_reg;

	// A write landing with a load keeps the holding register full
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			holdFull_reg <= 1'b0;
		end else if (txState.holdWrite) begin
			holdFull_reg <= 1'b1;
		end else if (txState.holdLoad) begin
			holdFull_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Sticky error flags
	// ------------------------------------------------------------
	logic breakFlag_reg, overFlag_reg, frameFlag_reg, parFlag_reg, underFlag_reg;
	logic overrunNow;

	// Arrival while the previous one is unread and not being read now
	assign overrunNow = rxEvents.charDone && rxPending_reg && !rdRhr;

	// Set always beats the status reset command
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			breakFlag_reg <= 1'b0;
			overFlag_reg <= 1'b0;
			frameFlag_reg <= 1'b0;
			parFlag_reg <= 1'b0;
			underFlag_reg <= 1'b0;
		end else begin
			breakFlag_reg <= rxEvents.breakSeen || (breakFlag_reg && !rstStatus);
			overFlag_reg <= overrunNow || (overFlag_reg && !rstStatus);
			frameFlag_reg <= rxEvents.frameErr || (frameFlag_reg && !rstStatus);
			parFlag_reg <= rxEvents.parityErr || (parFlag_reg && !rstStatus);
			underFlag_reg <= (spiMode && rxEvents.underrun) || (underFlag_reg && !rstStatus);
		end
	end

	// ------------------------------------------------------------
	// Timeout
	// ------------------------------------------------------------
	logic toutFlag_reg;

	// The start command clears; an expiry in the same cycle still counts
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			toutFlag_reg <= 1'b0;
		end else begin
			toutFlag_reg <= (rxEvents.timeoutHit && (rtor_reg != '0)) ||
				(toutFlag_reg && !startTimeout);
		end
	end

	// ------------------------------------------------------------
	// DMA buffer flags
	// ------------------------------------------------------------
	logic rx_dma_done_flag_reg, tx_dma_done_flag_reg, rx_dma_buffer_full_flag_reg, tx_dma_buffer_empty_flag_reg;

	// End flags sticky until counter write; full/empty follow counters
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx_dma_done_flag_reg <= 1'b0;
			tx_dma_done_flag_reg <= 1'b0;
			rx_dma_buffer_full_flag_reg <= 1'b0;
			tx_dma_buffer_empty_flag_reg <= 1'b0;
		end else begin
			rx_dma_done_flag_reg <= dmaState.rxReachedZero || (rx_dma_done_flag_reg && !dmaState.rxCntWrite);
			tx_dma_done_flag_reg <= dmaState.txReachedZero || (tx_dma_done_flag_reg && !dmaState.txCntWrite);
			rx_dma_buffer_full_flag_reg <= dmaState.rxBothZero && !dmaState.rxCntWrite;
			tx_dma_buffer_empty_flag_reg <= dmaState.txBothZero && !dmaState.txCntWrite;
		end
	end

	// ------------------------------------------------------------
	// Flow-control / select line
	// ------------------------------------------------------------
	logic flowPrev_reg, flowChg_reg;

	// Previous level for edge detection; pin is already synchronous
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flowPrev_reg <= 1'b0;
		end else begin
			flowPrev_reg <= flowIn;
		end
	end

	// Either edge sets; a status read clears unless an edge arrives too
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flowChg_reg <= 1'b0;
		end else begin
			flowChg_reg <= (flowIn != flowPrev_reg) || (flowChg_reg && !rdCsr);
		end
	end

	// ------------------------------------------------------------
	// Status view
	// ------------------------------------------------------------
	logic [31:0] csrVec;

	// Layout picked by mode; unlisted positions stay zero
	always_comb begin
		csrVec = 32'h0000_0000;
		csrVec[usart_status_pkg::B_RX_READY] = rxPending_reg && rxEnable;
		csrVec[usart_status_pkg::B_TX_READY] = txEnable && !holdFull_reg &&
			!(txState.breakPending && !spiMode);
		csrVec[usart_status_pkg::B_RX_END] = rx_dma_done_flag_reg;
		csrVec[usart_status_pkg::B_TX_END] = tx_dma_done_flag_reg;
		csrVec[usart_status_pkg::B_OVR] = overFlag_reg;
		csrVec[usart_status_pkg::B_TX_EMPTY] = txEnable && !holdFull_reg &&
			!txState.shiftBusy;
		csrVec[usart_status_pkg::B_TX_BUF_EMPTY] = tx_dma_buffer_empty_flag_reg;
		csrVec[usart_status_pkg::B_RX_BUF_FULL] = rx_dma_buffer_full_flag_reg;
		csrVec[usart_status_pkg::B_FLOWCHG] = flowChg_reg;
		csrVec[usart_status_pkg::B_FLOWLVL] = flowPrev_reg;
		if (spiMode) begin
			csrVec[usart_status_pkg::B_UNDER] = underFlag_reg;
		end else begin
			csrVec[usart_status_pkg::B_BREAK] = breakFlag_reg;
			csrVec[usart_status_pkg::B_FRAME] = frameFlag_reg;
			csrVec[usart_status_pkg::B_PAR] = parFlag_reg;
			csrVec[usart_status_pkg::B_TOUT] = toutFlag_reg && (rtor_reg != '0);
		end
	end

	// ------------------------------------------------------------
	// Read data and interrupt
	// ------------------------------------------------------------
	logic [31:0] rhrVec;

	// Holding word: character low, marker at bit 15, rest zero
	always_comb begin
		rhrVec = 32'h0000_0000;
		rhrVec[CHAR_W-1:0] = rxChar_reg;
		rhrVec[usart_status_pkg::RHR_SYNC_BIT] = rxSync_reg;
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			regRdata <= 32'h0000_0000;
		end else if (!regRd) begin
			regRdata <= 32'h0000_0000;
		end else begin
			case (regAddr)
				usart_status_pkg::MODE_ADDR: regRdata <= {28'h000_0000, mode_reg};
				usart_status_pkg::IMR_ADDR: regRdata <= imr_reg;
				usart_status_pkg::CSR_ADDR: regRdata <= csrVec;
				usart_status_pkg::RHR_ADDR: regRdata <= rhrVec;
				usart_status_pkg::RTOR_ADDR: regRdata <= {16'h0000, rtor_reg};
				default: regRdata <= 32'h0000_0000;
			endcase
		end
	end

	// Level interrupt, one cycle behind the flags
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(csrVec & imr_reg);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_ready_read_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rdRhr && !rxEvents.charDone |=> !csrVec[usart_status_pkg::B_RX_READY])
		else $error("ready flag survived holding read");

	a_ready_after_char: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rxEvents.charDone && rxEnable ##1 rxEnable |-> csrVec[usart_status_pkg::B_RX_READY])
		else $error("ready flag missing after character");

	a_ready_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!rxEnable |-> !csrVec[usart_status_pkg::B_RX_READY])
		else $error("ready flag set while receiver disabled");

	a_txready_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		txState.holdWrite |=> !csrVec[usart_status_pkg::B_TX_READY] && !csrVec[usart_status_pkg::B_TX_EMPTY])
		else $error("transmit ready after holding write");

	a_overrun_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
		overrunNow ##1 !rstStatus [*3] |=> csrVec[usart_status_pkg::B_OVR])
		else $error("overrun flag lost before status reset");

	a_break_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rxEvents.breakSeen && !spiMode ##1 !spiMode |-> csrVec[usart_status_pkg::B_BREAK])
		else $error("break flag not set");

	a_timeout_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rtor_reg == '0 |-> !csrVec[usart_status_pkg::B_TOUT])
		else $error("timeout flag with zero timeout value");

	a_flow_change: assert property (@(posedge clk_sys) disable iff (sys_rst)
		flowIn != $past(flowIn) |=> csrVec[usart_status_pkg::B_FLOWCHG] &&
		csrVec[usart_status_pkg::B_FLOWLVL] == $past(flowIn))
		else $error("flow edge not recorded");

	a_async_layout: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!spiMode |-> !csrVec[usart_status_pkg::B_UNDER])
		else $error("underrun bit shown outside SPI mode");

	a_irq_masked: assert property (@(posedge clk_sys) disable iff (sys_rst)
		imr_reg == 32'h0000_0000 |=> !irq)
		else $error("interrupt raised with all flags masked");

	a_read_only_once: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!regRd |=> regRdata == 32'h0000_0000)
		else $error("read data outside the read reply cycle");

endmodule : usart_status_rx

/* File: verif/serial_peer.sv */
/*
 * Remote serial node model: receive events, transmit and DMA state, flow pin.
 * Assumes the bench calls its tasks from one process, on clk_sys.
 */
`timescale 1ns/1ps

module serial_peer (
	// Clock
	input wire logic clk_sys,
	// Line side towards the status block
	output usart_status_pkg::rxEvents_t rxEvents,
	output usart_status_pkg::txState_t txState,
	output usart_status_pkg::dmaState_t dmaState,
	output logic flowIn
);
	// --------------------------------
	// Idle line
	// --------------------------------
	initial begin
		rxEvents = '0;
		txState = '0;
		dmaState = '0;
		flowIn = 1'b0;
	end

	// One-cycle event; data turned over afterwards so stale bits never look valid
	task automatic rxPulse(input usart_status_pkg::rxEvents_t e);
		usart_status_pkg::rxEvents_t idle;
		idle = '0;
		idle.charData = ~e.charData;
		@(posedge clk_sys);
		rxEvents <= e;
		@(posedge clk_sys);
		rxEvents <= idle;
	endtask : rxPulse

	// Pulses last one cycle, levels stay as given
	task automatic setState(input usart_status_pkg::txState_t t, input usart_status_pkg::dmaState_t d);
		@(posedge clk_sys);
		txState <= t;
		dmaState <= d;
		@(posedge clk_sys);
		txState <= usart_status_pkg::txState_t'(t & 4'b0011);
		dmaState <= usart_status_pkg::dmaState_t'(d & 6'b001001);
	endtask : setState

	// Flow pin, also the select line in SPI mode
	task automatic setFlow(input logic v);
		@(posedge clk_sys);
		flowIn <= v;
	endtask : setFlow
endmodule : serial_peer

/* File: verif/tb.sv */
/*
 * Self-checking bench for the status and receive holding block.
 * Assumes the package and the peer model are compiled first.
 */
`timescale 1ns/1ps

module tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [31:0] regAddr = '0;
	logic [31:0] regWdata = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata;
	logic rxEnable = 1'b1;
	logic txEnable = 1'b0;
	logic irq;
	usart_status_pkg::rxEvents_t rxEvents;
	usart_status_pkg::txState_t txState;
	usart_status_pkg::dmaState_t dmaState;
	logic flowIn;
	int failures = 0;
	int n_compared = 0;
	int seed = 32'h7592_c02b;
	// Behavioural model state
	logic [31:0] flags = '0;
	logic [31:0] rhr = '0;
	logic pend = 1'b0;
	logic holdFull = 1'b0;
	logic spi = 1'b0;
	logic rtorNz = 1'b0;

	always #5 clk_sys = ~clk_sys;

	usart_status_rx u_usart_status_rx (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxEvents(rxEvents),
		.txState(txState), .dmaState(dmaState), .rxEnable(rxEnable), .txEnable(txEnable),
		.flowIn(flowIn), .irq(irq));
	serial_peer u_peer (.clk_sys(clk_sys), .rxEvents(rxEvents), .txState(txState), .dmaState(dmaState),
		.flowIn(flowIn));

	// --------------------------------
	// Checking and closing
	// --------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	// Hidden bits follow the layout; timeout stays hidden while its value is zero
	function automatic logic [31:0] expCsr();
		logic [31:0] s;
		s = flags;
		s[0] = pend & rxEnable;
		s[1] = txEnable & !holdFull & !txState.breakPending;
		s[8] = flags[8] & rtorNz;
		s[9] = txEnable & !holdFull & !txState.shiftBusy;
		s[11] = dmaState.txBothZero;
		s[12] = dmaState.rxBothZero;
		s[23] = flowIn;
		return s & (spi ? 32'h0088_1E3B : 32'h0088_1BFF);
	endfunction : expCsr

	// --------------------------------
	// Register port master
	// --------------------------------
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
		if (a == usart_status_pkg::CMD_ADDR && d[8]) flags &= ~32'h0000_04E4;
		if (a == usart_status_pkg::CMD_ADDR && d[11]) flags[8] = 1'b0;
	endtask : wr

	// Data is taken in the one cycle after the read edge
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdata;
		if (a == usart_status_pkg::CSR_ADDR) flags[19] = 1'b0;
		if (a == usart_status_pkg::RHR_ADDR) pend = 1'b0;
	endtask : rd

	task automatic chkRd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		check(v, exp);
	endtask : chkRd

	// Let levels driven at this edge settle before the model reads them
	task automatic chkCsr();
		logic [31:0] e;
		#1;
		e = expCsr();
		chkRd(usart_status_pkg::CSR_ADDR, e);
	endtask : chkCsr

	// --------------------------------
	// Stimulus with model update
	// --------------------------------
	task automatic ev(input usart_status_pkg::rxEvents_t e);
		u_peer.rxPulse(e);
		if (e.charDone) begin
			flags[5] = flags[5] | pend;
			pend = 1'b1;
			rhr = {16'h0000, e.charSync, 6'h00, e.charData};
		end
		flags[2] = flags[2] | e.breakSeen;
		flags[6] = flags[6] | e.frameErr;
		flags[7] = flags[7] | e.parityErr;
		flags[8] = flags[8] | (e.timeoutHit & rtorNz);
		flags[10] = flags[10] | (e.underrun & spi);
	endtask : ev

	task automatic st(input logic [3:0] t, input logic [5:0] d);
		u_peer.setState(usart_status_pkg::txState_t'(t), usart_status_pkg::dmaState_t'(d));
		holdFull = t[3] | (holdFull & !t[2]);
		flags[3] = d[5] | (flags[3] & !d[4]);
		flags[4] = d[2] | (flags[4] & !d[1]);
	endtask : st

	task automatic flow(input logic v);
		flags[19] = flags[19] | (v != flowIn);
		u_peer.setFlow(v);
	endtask : flow

	task automatic chr(input logic sync);
		usart_status_pkg::rxEvents_t e;
		e = '0;
		e.charDone = 1'b1;
		e.charData = 9'($random(seed));
		e.charSync = sync;
		ev(e);
	endtask : chr

	// --------------------------------
	// Watchdog
	// --------------------------------
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		conclude();
	end

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		usart_status_pkg::rxEvents_t e;
		logic [5:0] dmaSeq [4];
		dmaSeq = '{6'b100000, 6'b010000, 6'b001101, 6'b000010};
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chkCsr();
		chkRd(usart_status_pkg::IMR_ADDR, 32'h0000_0000);
		chkRd(usart_status_pkg::RTOR_ADDR, 32'h0000_0000);
		// Characters, holding register read and clear
		for (int i = 0; i < 3; i++) begin
			chr(i[0]);
			chkCsr();
			chkRd(usart_status_pkg::RHR_ADDR, rhr);
			chkCsr();
		end
		// Overrun, then error pulses; underrun is ignored outside SPI
		chr(1'b0);
		chr(1'b1);
		chkCsr();
		e = '0;
		e.breakSeen = 1'b1;
		e.frameErr = 1'b1;
		e.parityErr = 1'b1;
		e.underrun = 1'b1;
		ev(e);
		wr(usart_status_pkg::CSR_ADDR, 32'hFFFF_FFFF);
		chkCsr();
		wr(usart_status_pkg::CMD_ADDR, 32'h0000_0100);
		chkCsr();
		chkRd(usart_status_pkg::RHR_ADDR, rhr);
		chkRd(32'h4002_4030, 32'h0000_0000);
		// Character arrives while the receiver is off
		@(posedge clk_sys);
		rxEnable <= 1'b0;
		chr(1'b0);
		chkCsr();
		@(posedge clk_sys);
		rxEnable <= 1'b1;
		chkCsr();
		chkRd(usart_status_pkg::RHR_ADDR, rhr);
		// Timeout with zero value, then with a real value
		e = '0;
		e.timeoutHit = 1'b1;
		ev(e);
		chkCsr();
		wr(usart_status_pkg::CMD_ADDR, 32'h0000_0800);
		wr(usart_status_pkg::RTOR_ADDR, 32'h0000_0005);
		rtorNz = 1'b1;
		ev(e);
		chkCsr();
		wr(usart_status_pkg::CMD_ADDR, 32'h0000_0800);
		chkCsr();
		// Transmitter states
		@(posedge clk_sys);
		txEnable <= 1'b1;
		chkCsr();
		st(4'b1010, 6'b000000);
		chkCsr();
		st(4'b0110, 6'b000000);
		chkCsr();
		st(4'b0001, 6'b000000);
		chkCsr();
		st(4'b0000, 6'b000000);
		// Counter events, counter writes and buffer levels
		foreach (dmaSeq[k]) begin
			st(4'b0000, dmaSeq[k]);
			chkCsr();
		end
		// Flow pin change and level
		flow(1'b1);
		chkCsr();
		chkCsr();
		// Both SPI modes
		for (int m = 14; m < 16; m++) begin
			wr(usart_status_pkg::MODE_ADDR, 32'(m));
			spi = 1'b1;
			e = '0;
			e.underrun = 1'b1;
			e.frameErr = 1'b1;
			ev(e);
			flow(!flowIn);
			chkCsr();
			wr(usart_status_pkg::CMD_ADDR, 32'h0000_0100);
			chkCsr();
		end
		wr(usart_status_pkg::MODE_ADDR, 32'h0000_0000);
		spi = 1'b0;
		chkCsr();
		// Interrupt follows the mask
		chr(1'b1);
		wr(usart_status_pkg::IER_ADDR, 32'h0000_0001);
		chkRd(usart_status_pkg::IMR_ADDR, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		#1;
		check({31'h0, irq}, 32'h0000_0001);
		wr(usart_status_pkg::IDR_ADDR, 32'h0000_0001);
		repeat (3) @(posedge clk_sys);
		#1;
		check({31'h0, irq}, 32'h0000_0000);
		chkRd(usart_status_pkg::RHR_ADDR, rhr);
		conclude();
	end
endmodule : tb
